/* File: hdl/aarb_result_bank.sv */
/*
  Conversion sequencer, averaging accumulator, six result registers,
  read port and emitter gating of the optical front end.
  Assumes the timing engine strobes and the ADC handshake run on mclk;
  fault comparator inputs are asynchronous and are synchronised here.
*/
`include "aarb_consts.svh"

module aarb_result_bank
  import aarb_pkg::*;
#(
  parameter int INT_DIV = `AARB_INT_DIV,
  parameter int CONV_TICKS = `AARB_CONV_TICKS,
  parameter int CONV_CYCLES = `AARB_CONV_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Timing engine strobes
  input wire logic adc_reset_strobe,
  input wire logic adc_ready_strobe,
  input wire logic led_pulse_req,
  // First control word fields
  input wire logic [`AARB_AVG_W-1:0] average_count_field,
  input wire logic pulse_timer_run,
  input wire logic led_drive_enable,
  input wire logic third_emitter_select,
  // ADC conversion handshake
  output logic conv_start,
  input wire logic conv_valid,
  input wire logic [`AARB_CODE_W-1:0] conv_code,
  output logic conv_ready,
  // Emitter drive
  output logic led_drive_gate,
  output logic positive_emitter_output,
  output logic third_emitter_output,
  // Emitter fault comparators
  input wire logic txp_fault_pin,
  input wire logic tx3_fault_pin,
  output logic txp_diag_flag,
  // Result read port
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [`AARB_WORD_W-1:0] rd_data,
  output logic rd_hit,
  output logic data_ready
);

  localparam int TIMER_W = 16;
  localparam logic [TIMER_W-1:0] CONV_LAST = TIMER_W'(CONV_CYCLES - 1);

  // ****************************************************************
  // Strobe edges
  // ****************************************************************
  logic rst_d_reg, rdy_d_reg;
  logic rst_fall, rst_rise, rdy_rise;

  assign rst_fall = rst_d_reg & ~adc_reset_strobe;
  assign rst_rise = ~rst_d_reg & adc_reset_strobe;
  assign rdy_rise = ~rdy_d_reg & adc_ready_strobe;

  // Delayed strobes for edge detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_d_reg <= 1'b0;
      rdy_d_reg <= 1'b0;
    end else begin
      rst_d_reg <= adc_reset_strobe;
      rdy_d_reg <= adc_ready_strobe;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  aarb_conv_state_e state_reg, state_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [8:0] issued_reg, issued_next;
  logic [8:0] target_reg, target_next;
  logic start_reg, start_next;
  logic buf_in_ready;

  assign conv_start = start_reg;
  assign conv_ready = buf_in_ready;

  // Start conversions, one per conversion time, up to count plus one
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    issued_next = issued_reg;
    target_next = target_reg;
    start_next = 1'b0;
    if (rst_rise) begin
      state_next = AARB_IDLE;
    end else if (rst_fall && pulse_timer_run) begin
      target_next = {1'b0, average_count_field} + 9'h001;
      issued_next = 9'h001;
      timer_next = CONV_LAST;
      start_next = 1'b1;
      state_next = AARB_CONVERT;
    end else begin
      case (state_reg)
        AARB_IDLE: begin
          timer_next = timer_reg;
        end
        AARB_CONVERT: begin
          if (timer_reg != '0) begin
            timer_next = timer_reg - TIMER_W'(1);
          end else if (issued_reg == target_reg) begin
            state_next = AARB_FULL;
          end else if (buf_in_ready) begin
            issued_next = issued_reg + 9'h001;
            timer_next = CONV_LAST;
            start_next = 1'b1;
          end
        end
        AARB_FULL: begin
          state_next = AARB_FULL;
        end
        default: begin
          state_next = AARB_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= AARB_IDLE;
      timer_reg <= '0;
      issued_reg <= 9'h000;
      target_reg <= 9'h001;
      start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      issued_reg <= issued_next;
      target_reg <= target_next;
      start_reg <= start_next;
    end
  end

  // ****************************************************************
  // Sample buffer and accumulator
  // ****************************************************************
  logic buf_out_valid, buf_out_ready, take;
  aarb_code_t buf_out_data;
  logic signed [29:0] acc_reg, acc_next;
  logic [8:0] got_reg, got_next;
  logic signed [29:0] divisor;
  logic signed [29:0] quotient;
  aarb_code_t avg_code;

  aarb_two_entry_buf #(.W(`AARB_CODE_W)) u_buf (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(conv_valid),
    .in_data(conv_code),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(buf_out_ready)
  );

  // Drain stalls during the store cycle
  assign buf_out_ready = ~rst_rise;
  assign take = buf_out_valid & buf_out_ready;

  // Average of the accepted samples, at least one divisor
  assign divisor = (got_reg == 9'h000) ? 30'sd1 : $signed({21'h000000, got_reg});
  assign quotient = acc_reg / divisor;
  assign avg_code = quotient[`AARB_CODE_W-1:0];

  // Sum the samples of the current phase
  always_comb begin
    acc_next = acc_reg;
    got_next = got_reg;
    if (rst_rise || rst_fall) begin
      acc_next = '0;
      got_next = 9'h000;
    end else if (take) begin
      acc_next = acc_reg + 30'($signed(buf_out_data));
      got_next = got_reg + 9'h001;
    end
  end

  // Accumulator registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
      got_reg <= 9'h000;
    end else begin
      acc_reg <= acc_next;
      got_reg <= got_next;
    end
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************
  aarb_word_t res_reg [`AARB_RESULT_COUNT];
  aarb_word_t res_next [`AARB_RESULT_COUNT];
  logic [1:0] slot_reg, slot_next;
  aarb_word_t new_word;

  // Sign extension of a code into a full word
  function automatic aarb_word_t sext_word(input aarb_code_t c);
    sext_word = {{2{c[`AARB_CODE_MSB]}}, c};
  endfunction

  // Saturated difference of two codes, sign extended
  function automatic aarb_word_t diff_word(input aarb_code_t a, input aarb_code_t b);
    logic signed [22:0] d;
    aarb_code_t c;
    d = $signed({a[`AARB_CODE_MSB], a}) - $signed({b[`AARB_CODE_MSB], b});
    if (d > $signed(`AARB_CODE_MAX)) begin
      c = {1'b0, {21{1'b1}}};
    end else if (d < $signed(`AARB_CODE_MIN)) begin
      c = {1'b1, 21'h000000};
    end else begin
      c = d[`AARB_CODE_W-1:0];
    end
    diff_word = sext_word(c);
  endfunction

  assign new_word = sext_word(avg_code);

  // Store on each rising reset strobe, whole word in one cycle
  always_comb begin
    res_next = res_reg;
    slot_next = slot_reg;
    if (rst_rise) begin
      res_next[slot_reg] = new_word;
      slot_next = slot_reg + 2'h1;
      if (slot_reg == 2'h3) begin
        res_next[4] = diff_word(res_reg[0][21:0], res_reg[1][21:0]);
        res_next[5] = diff_word(res_reg[2][21:0], avg_code);
      end
    end
  end

  // Result registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `AARB_RESULT_COUNT; i++) begin
        res_reg[i] <= `AARB_RESULT_RESET;
      end
      slot_reg <= 2'h0;
    end else begin
      res_reg <= res_next;
      slot_reg <= slot_next;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [`AARB_WORD_W-1:0] rd_data_reg, rd_data_next;
  logic rd_hit_reg, rd_hit_next;
  logic data_ready_reg, data_ready_next;
  logic [7:0] rd_index;

  assign rd_index = rd_addr - `AARB_OFS_PHASE_FIRST;
  assign rd_data = rd_data_reg;
  assign rd_hit = rd_hit_reg;
  assign data_ready = data_ready_reg;

  // Address decode of the six results
  always_comb begin
    rd_data_next = rd_data_reg;
    rd_hit_next = 1'b0;
    data_ready_next = rdy_rise;
    if (!rd_en) begin
      rd_hit_next = 1'b0;
    end else if (rd_addr >= `AARB_OFS_PHASE_FIRST && rd_addr <= `AARB_OFS_COMBINED_B) begin
      rd_data_next = res_reg[rd_index[2:0]];
      rd_hit_next = 1'b1;
    end else begin
      rd_data_next = '0;
    end
  end

  // Read port registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_reg <= '0;
      rd_hit_reg <= 1'b0;
      data_ready_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_hit_reg <= rd_hit_next;
      data_ready_reg <= data_ready_next;
    end
  end

  // ****************************************************************
  // Emitter gating and diagnostics
  // ****************************************************************
  logic [1:0] txp_sync_reg, txp_sync_next;
  logic [1:0] tx3_sync_reg, tx3_sync_next;
  logic gate_reg, gate_next;
  logic pos_reg, pos_next;
  logic third_reg, third_next;
  logic diag_reg, diag_next;
  logic ambient;

  // Slot even means the sample window belongs to an ambient phase
  assign ambient = ~slot_reg[0];
  assign led_drive_gate = gate_reg;
  assign positive_emitter_output = pos_reg;
  assign third_emitter_output = third_reg;
  assign txp_diag_flag = diag_reg;

  // Gate, route and fault selection
  always_comb begin
    txp_sync_next = {txp_sync_reg[0], txp_fault_pin};
    tx3_sync_next = {tx3_sync_reg[0], tx3_fault_pin};
    gate_next = led_pulse_req & led_drive_enable & pulse_timer_run & ~ambient;
    pos_next = gate_next & ~third_emitter_select;
    third_next = gate_next & third_emitter_select;
    diag_next = third_emitter_select ? tx3_sync_reg[1] : txp_sync_reg[1];
  end

  // Emitter registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txp_sync_reg <= 2'h0;
      tx3_sync_reg <= 2'h0;
      gate_reg <= 1'b0;
      pos_reg <= 1'b0;
      third_reg <= 1'b0;
      diag_reg <= 1'b0;
    end else begin
      txp_sync_reg <= txp_sync_next;
      tx3_sync_reg <= tx3_sync_next;
      gate_reg <= gate_next;
      pos_reg <= pos_next;
      third_reg <= third_next;
      diag_reg <= diag_next;
    end
  end

endmodule

/* File: hdl/aarb_consts.svh */
/*
  Constants of the averaging result bank: register offsets, field widths
  and conversion timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef AARB_CONSTS_SVH
`define AARB_CONSTS_SVH

// ****************************************************************
// Result register offsets
// ****************************************************************
`define AARB_OFS_PHASE_FIRST 8'h2a
`define AARB_OFS_PHASE_SECOND 8'h2b
`define AARB_OFS_PHASE_THIRD 8'h2c
`define AARB_OFS_PHASE_FOURTH 8'h2d
`define AARB_OFS_COMBINED_A 8'h2e
`define AARB_OFS_COMBINED_B 8'h2f
`define AARB_RESULT_COUNT 6

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define AARB_CODE_W 22
`define AARB_WORD_W 24
`define AARB_CODE_MSB 21
`define AARB_AVG_W 8
`define AARB_RESULT_RESET 24'h000000
`define AARB_CODE_MAX 23'h1fffff
`define AARB_CODE_MIN 23'h600000

// ****************************************************************
// Conversion timing
// ****************************************************************
`define AARB_CONV_TIME_NS 50000
`define AARB_MCLK_PERIOD_NS 10
`define AARB_INT_PERIOD_NS 250
`define AARB_CONV_TICKS (`AARB_CONV_TIME_NS / `AARB_INT_PERIOD_NS)
`define AARB_INT_DIV (`AARB_INT_PERIOD_NS / `AARB_MCLK_PERIOD_NS)
`define AARB_CONV_CYCLES (`AARB_CONV_TICKS * `AARB_INT_DIV)

`endif

/* File: hdl/aarb_pkg.sv */
/*
  Types shared by the averaging result bank modules.
  Assumes the constants header is on the include path.
*/
`include "aarb_consts.svh"

package aarb_pkg;

  // ****************************************************************
  // Data types
  // ****************************************************************
  typedef logic [`AARB_CODE_W-1:0] aarb_code_t;
  typedef logic [`AARB_WORD_W-1:0] aarb_word_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    AARB_IDLE,
    AARB_CONVERT,
    AARB_FULL
  } aarb_conv_state_e;

endpackage

/* File: hdl/aarb_two_entry_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
module aarb_two_entry_buf
  import aarb_pkg::*;
#(
  parameter int W = 22
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  logic [W-1:0] mem_reg [2];
  logic [W-1:0] mem_next [2];
  logic wr_ptr_reg, wr_ptr_next;
  logic rd_ptr_reg, rd_ptr_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;

  // Honest full and empty
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

/* File: bench/aarb_result_bank_chk.sv */
/*
  Port checker of the averaging result bank.
  Assumes binding into aarb_result_bank, one clock, active-low reset.
*/
`include "aarb_consts.svh"
module aarb_result_bank_chk
  import aarb_pkg::*;
#(
  parameter int CONV_CYCLES = `AARB_CONV_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Strobes and control
  input wire logic adc_reset_strobe,
  input wire logic adc_ready_strobe,
  input wire logic pulse_timer_run,
  input wire logic led_drive_enable,
  input wire logic third_emitter_select,
  // Watched outputs and read port inputs
  input wire logic conv_start,
  input wire logic led_drive_gate,
  input wire logic positive_emitter_output,
  input wire logic third_emitter_output,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [`AARB_WORD_W-1:0] rd_data,
  input wire logic rd_hit,
  input wire logic data_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic in_map;
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Decode of the six result offsets
  assign in_map = (rd_addr >= 8'h2a) && (rd_addr <= 8'h2f);
  // Cycles since last conversion start, saturating
  always_comb begin
    gap_next = gap_reg;
    if (conv_start) gap_next = 16'h0001;
    else if (gap_reg != 16'h0000 && gap_reg != 16'hffff) gap_next = gap_reg + 16'h0001;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) gap_reg <= 16'h0000;
    else gap_reg <= gap_next;
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_strobe_fall;
    $fell(adc_reset_strobe) && pulse_timer_run;
  endsequence
  sequence s_ready_rise;
    $rose(adc_ready_strobe);
  endsequence
  sequence s_ready_pulse;
    ##[1:2] data_ready ##1 !data_ready;
  endsequence
  a_read_answer: assert property (rd_en && in_map |=> rd_hit)
    else $error("mapped read gave no hit");
  a_hit_cause: assert property (rd_hit |-> $past(rd_en) && $past(in_map))
    else $error("hit without mapped read");
  a_unmapped_zero: assert property (rd_en && !in_map |=> !rd_hit && rd_data == 24'h000000)
    else $error("unmapped read not zero");
  a_sign_copy: assert property (rd_hit |-> rd_data[23:22] == {2{rd_data[21]}})
    else $error("upper bits do not copy sign");
  a_fall_starts: assert property (s_strobe_fall |=> conv_start)
    else $error("no conversion after strobe fall");
  a_start_spacing: assert property (conv_start && gap_reg != 0 |-> gap_reg >= CONV_CYCLES)
    else $error("conversion starts too close");
  a_ready_pulse: assert property (s_ready_rise |-> s_ready_pulse)
    else $error("data ready pulse wrong");
  a_gate_cause: assert property (led_drive_gate |-> $past(led_drive_enable) && $past(pulse_timer_run))
    else $error("gate on while disabled");
  a_emitter_route: assert property (positive_emitter_output || third_emitter_output |->
    third_emitter_output == $past(third_emitter_select) && !(positive_emitter_output && third_emitter_output))
    else $error("emitter routing wrong");
endmodule

bind aarb_result_bank aarb_result_bank_chk #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.mclk, .arst_n,
  .adc_reset_strobe, .adc_ready_strobe, .pulse_timer_run, .led_drive_enable,
  .third_emitter_select, .conv_start, .led_drive_gate, .positive_emitter_output,
  .third_emitter_output, .rd_en, .rd_addr, .rd_data, .rd_hit, .data_ready);

/* File: bench/aarb_adc_model.sv */
/*
  Behavioural ADC answering each conversion start with one random code.
  Assumes conv_ready from the bank and starts spaced wider than 7 cycles.
*/
module aarb_adc_model
  import aarb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Conversion handshake
  input wire logic conv_start,
  input wire logic conv_ready,
  output logic conv_valid,
  output aarb_code_t conv_code
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  // Random latency, word held until taken, garbage when idle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_valid <= 1'b0;
      conv_code <= '0;
      wait_n <= 0;
    end else if (conv_valid) begin
      if (conv_ready) conv_valid <= 1'b0;
    end else begin
      conv_code <= ~conv_code;
      if (conv_start) wait_n <= $urandom_range(6, 1);
      else if (wait_n == 1) begin
        conv_valid <= 1'b1;
        conv_code <= 22'($urandom); // twos complement code, full range
        wait_n <= 0;
      end else if (wait_n > 1) wait_n <= wait_n - 1;
    end
  end
endmodule

/* File: bench/aarb_result_bank_tb.sv */
/*
  Self-checking bench of the averaging result bank.
  Assumes the ADC model on the conversion side and the bound checker.
*/
module aarb_result_bank_tb
  import aarb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 8;
  logic mclk, arst_n, adc_reset_strobe, adc_ready_strobe, led_pulse_req, pulse_timer_run;
  logic led_drive_enable, third_emitter_select, conv_start, conv_valid, conv_ready;
  logic led_drive_gate, positive_emitter_output, third_emitter_output;
  logic txp_fault_pin, tx3_fault_pin, txp_diag_flag, rd_en, rd_hit, data_ready;
  logic [7:0] average_count_field, rd_addr;
  logic [7:0] n_tab [11] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h00, 8'h02, 8'h03, 8'h01,
    8'h02, 8'h00, 8'h03};
  aarb_code_t conv_code;
  aarb_word_t rd_data;
  aarb_word_t exp_res [6];
  aarb_word_t exp_q [$];
  int fails, n_compared, n_starts, acc_n, slot;
  longint acc_sum;

  // ****************************************************************
  // Design, ADC model, clock
  // ****************************************************************
  aarb_result_bank #(.CONV_CYCLES(CONV)) i_dut (.mclk, .arst_n, .adc_reset_strobe,
    .adc_ready_strobe, .led_pulse_req, .average_count_field, .pulse_timer_run,
    .led_drive_enable, .third_emitter_select, .conv_start, .conv_valid, .conv_code,
    .conv_ready, .led_drive_gate, .positive_emitter_output, .third_emitter_output,
    .txp_fault_pin, .tx3_fault_pin, .txp_diag_flag, .rd_en, .rd_addr, .rd_data, .rd_hit,
    .data_ready);
  aarb_adc_model i_adc (.mclk, .arst_n, .conv_start, .conv_ready, .conv_valid, .conv_code);
  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input string what, input aarb_word_t seen, input aarb_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic aarb_word_t word_of(input longint v);
    aarb_code_t c;
    c = v[21:0];
    return {{2{c[21]}}, c};
  endfunction
  function automatic longint sat22(input longint v);
    if (v > 2097151) return 2097151;
    if (v < -2097152) return -2097152;
    return v;
  endfunction
  // Read results as they appear, oldest note first
  always @(negedge mclk) begin
    if (rd_hit === 1'b1) begin
      if (exp_q.size() == 0) check("spurious rd_hit", 24'h000001, 24'h000000);
      else check("rd_data", rd_data, exp_q.pop_front());
    end
  end
  // Accepted ADC words and conversion starts
  always @(posedge mclk) begin
    if (conv_valid === 1'b1 && conv_ready === 1'b1) begin
      acc_sum += $signed(conv_code);
      acc_n++;
    end
    if (conv_start === 1'b1) n_starts++;
  end

  // ****************************************************************
  // Stimulus tasks
  // ****************************************************************
  task automatic rd(input logic [7:0] a);
    logic hit;
    hit = (a >= 8'h2a) && (a <= 8'h2f);
    rd_en = 1'b1;
    rd_addr = a;
    if (hit) exp_q.push_back(exp_res[a - 8'h2a]);
    @(negedge mclk);
    if (!hit) begin
      check("unmapped rd_hit", {23'h0, rd_hit}, 24'h000000);
      check("unmapped rd_data", rd_data, 24'h000000);
    end
  endtask
  // Back-to-back reads around and across the result window
  task automatic read_all();
    for (int a = 8'h29; a <= 8'h30; a++) rd(8'(a));
    rd_en = 1'b0;
  endtask
  // Store at strobe rise: average of the phase, combined on the wrap
  task automatic store();
    longint v;
    v = (acc_n == 0) ? 0 : acc_sum / acc_n;
    exp_res[slot] = word_of(v);
    if (slot == 3) begin
      exp_res[4] = word_of(sat22($signed(exp_res[0]) - $signed(exp_res[1])));
      exp_res[5] = word_of(sat22($signed(exp_res[2]) - $signed(exp_res[3])));
    end
    slot = (slot + 1) % 4;
    acc_sum = 0;
    acc_n = 0;
  endtask
  task automatic phase(input logic [7:0] n, input logic run);
    adc_reset_strobe = 1'b1;
    store();
    average_count_field = n;
    pulse_timer_run = run;
    led_drive_enable = run;
    third_emitter_select = 1'($urandom);
    led_pulse_req = 1'($urandom);
    {txp_fault_pin, tx3_fault_pin} = 2'($urandom);
    repeat (3) @(negedge mclk);
    if (slot == 0) begin
      adc_ready_strobe = 1'b1;
      @(negedge mclk);
      check("data ready", {23'h0, data_ready}, 24'h000001);
      @(negedge mclk);
      check("data ready end", {23'h0, data_ready}, 24'h000000);
      adc_ready_strobe = 1'b0;
      read_all();
    end
    adc_reset_strobe = 1'b0;
    n_starts = 0;
    repeat (5) @(negedge mclk);
    check("led gate", {23'h0, led_drive_gate}, {23'h0, run & slot[0] & led_pulse_req});
    check("positive out", {23'h0, positive_emitter_output},
      {23'h0, run & slot[0] & led_pulse_req & !third_emitter_select});
    check("third out", {23'h0, third_emitter_output},
      {23'h0, run & slot[0] & led_pulse_req & third_emitter_select});
    check("diag flag", {23'h0, txp_diag_flag},
      {23'h0, third_emitter_select ? tx3_fault_pin : txp_fault_pin});
    repeat ((n + 1) * CONV + 16) @(negedge mclk);
    check("start count", 24'(n_starts), run ? 24'(n) + 24'h000001 : 24'h000000);
    check("conv ready", {23'h0, conv_ready}, 24'h000001);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    adc_reset_strobe = 1'b0;
    adc_ready_strobe = 1'b0;
    led_pulse_req = 1'b1;
    average_count_field = 8'h00;
    pulse_timer_run = 1'b0;
    led_drive_enable = 1'b0;
    third_emitter_select = 1'b0;
    txp_fault_pin = 1'b0;
    tx3_fault_pin = 1'b0;
    rd_en = 1'b0;
    rd_addr = 8'h00;
    fails = 0;
    n_compared = 0;
    n_starts = 0;
    acc_n = 0;
    acc_sum = 0;
    slot = 0;
    foreach (exp_res[i]) exp_res[i] = 24'h000000;
    void'($urandom(92966));
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    read_all();
    foreach (n_tab[i]) phase(n_tab[i], 1'b1);
    phase(8'h00, 1'b0);
    conclude();
  end
  // Cut a hang short
  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule
